// ### pkg/lpw_defs.svh
// Offsets, field positions and reset values of the wake-up source block
`ifndef LPW_DEFS_SVH
`define LPW_DEFS_SVH
`define LPW_OFS_LOW_POWER_CTRL 8'h00
`define LPW_OFS_PORT3_WAKE_FLAGS 8'h1c
`define LPW_OFS_PORT3_WAKE_ENABLE 8'h20
`define LPW_OFS_PERIPHERAL_WAKE_FLAGS 8'h30
`define LPW_OFS_PERIPHERAL_WAKE_ENABLE 8'h34
`define LPW_OFS_RETAINED_SCRATCH_0 8'h48
`define LPW_OFS_RETAINED_SCRATCH_1 8'h4c
`define LPW_OFS_IRQ_STATUS 8'h60
`define LPW_OFS_IRQ_ENABLE 8'h64
`define LPW_OFS_IRQ_CLEAR 8'h68
`define LPW_OFS_POWER_MGMT 8'h6c
`define LPW_BIT_FLAG_CLEAR_ALL 31
`define LPW_BIT_RESET_WAKE 17
`define LPW_BIT_BACKUP_WAKE 16
`define LPW_BIT_COMPARATOR_ZERO_WAKE_WAKE 4
`define LPW_BIT_GLOBAL_PIN_WAKE 0
`define LPW_PORT3_MASK 32'h0000_0003
`define LPW_PERIPH_FLAG_MASK 32'h0003_0010
`define LPW_PERIPH_EN_MASK 32'h07ff_ff10
`define LPW_RESET_VALUE 32'h0000_0000
`define LPW_PERIPH_LO 8
`define LPW_PERIPH_HI 26
`define LPW_IRQ_PIN_WAKE 0
`define LPW_IRQ_PERIPH_WAKE 1
`define LPW_IRQ_WAKE_DONE 2
`endif

// ### pkg/lpw_pkg.sv
// Types of the wake-up source block
package lpw_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lpw_bus_req_t;
  typedef enum logic [1:0] {LPW_ACTIVE, LPW_LOW_POWER, LPW_WAKING} lpw_state_t;
endpackage : lpw_pkg

// ### logic/lpw_wake_sources.sv
// Wake-up source collection, wake flags, retained scratch and wake interrupt
//
// Operation
// - Enabled port-3 pin level change wakes device from low power to active
// - Pin wake event sets that pin's flag bit
// - Pin wake also needs the global pin wake enable set
// - Peripheral flag bit 17 records wake caused by external reset
// - Peripheral flag bit 16 records wake from backup mode
// - Peripheral flag bit 4 records wake by comparator zero
// - Enable bit 26 gates low-power comparator wake
// - Enable bits 25 and 24 gate SPI port-1 and I2S wake
// - Enable bits 23 to 21 gate I2C 2, 1, 0 wake
// - Enable bits 20 to 17 gate UART 3 to 0 wake
// - Enable bits 16 to 11 gate timers 5 to 0 wake
// - Enable bit 10 gates secondary core wake
// - Enable bits 9 and 8 gate watchdog one and zero wake
// - Enable bit 0 blocks, 1 allows; all reset to 0
// - Two 32-bit scratch registers reset to 0 and retain through low power
// - Pin flag set on either edge in any power mode
// - Writing bit 31 of control clears all flags, then self-clears
`timescale 1ns/1ps
`default_nettype none
`include "lpw_defs.svh"

module lpw_wake_sources (
  input wire logic ref_clk, // System clock, 125 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [1:0] port3_pin, // Port-3 wake pins, asynchronous
  input wire logic [31:0] periph_irq, // Peripheral interrupts by enable bit
  input wire logic ext_reset_wake, // Wake caused by external reset, pulse
  input wire logic backup_wake, // Wake from backup mode, pulse
  input wire logic comparator_zero_wake, // Comparator zero wake trigger, pulse
  input wire logic sleep_req, // Processor requests low power, pulse
  output logic low_power_state, // High while in low power
  output logic wake_req, // One-cycle wake request
  output logic irq // Level interrupt
);
  lpw_pkg::lpw_bus_req_t bus;
  lpw_pkg::lpw_state_t state_reg, state_next;
  logic rst_s1_reg, rst_sync_reg;
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_last_reg;
  logic [31:0] p3_en_reg, p3_flag_reg, p3_flag_next;
  logic [31:0] pw_en_reg, pw_flag_reg, pw_flag_next;
  logic [31:0] scratch0_reg, scratch1_reg;
  logic clear_all_reg, gpw_en_reg;
  logic [2:0] ist_reg, ist_next, ien_reg;
  logic [31:0] rdata_next;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic wr_hit(input lpw_pkg::lpw_bus_req_t b, input logic [7:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction : wr_hit

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_sync_reg <= rst_s1_reg;
    end
  end

  // Pin synchronisers; edge detect compares second stage with the third stage after it
  always_ff @(posedge ref_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      pin_last_reg <= 2'h0;
    end
    else
    begin
      pin_s1_reg <= port3_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_last_reg <= pin_s2_reg;
    end
  end

  wire pins_primed;
  logic primed_reg, primed2_reg;
  always_ff @(posedge ref_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      primed_reg <= 1'b0;
      primed2_reg <= 1'b0;
    end
    else
    begin
      primed_reg <= 1'b1;
      primed2_reg <= primed_reg;
    end
  end
  assign pins_primed = primed2_reg;

  wire [1:0] pin_edge = pins_primed ? (pin_s2_reg ^ pin_last_reg) : 2'h0;
  wire [31:0] pin_evt = {30'h0, pin_edge};
  wire pin_wake = gpw_en_reg && |(pin_edge & p3_en_reg[1:0]);

  // Peripheral gating, one enable bit per source
  wire [31:0] periph_gated;
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : gate_gen
      if (g >= `LPW_PERIPH_LO && g <= `LPW_PERIPH_HI)
      begin : live
        assign periph_gated[g] = periph_irq[g] & pw_en_reg[g];
      end
      else
      begin : dead
        assign periph_gated[g] = 1'b0;
      end
    end
  endgenerate
  wire periph_wake = |periph_gated;

  wire [31:0] pw_evt = {14'h0, ext_reset_wake, backup_wake, 11'h0, comparator_zero_wake, 4'h0};
  wire comp_wake = comparator_zero_wake && pw_en_reg[`LPW_BIT_COMPARATOR_ZERO_WAKE_WAKE];
  wire any_wake = pin_wake || periph_wake || comp_wake || ext_reset_wake || backup_wake;

  wire w_ctrl = wr_hit(bus, `LPW_OFS_LOW_POWER_CTRL);
  wire w_p3f = wr_hit(bus, `LPW_OFS_PORT3_WAKE_FLAGS);
  wire w_pwf = wr_hit(bus, `LPW_OFS_PERIPHERAL_WAKE_FLAGS);
  wire [31:0] p3_clr = clear_all_reg ? 32'hffff_ffff : (w_p3f ? bus.wdata : 32'h0);
  wire [31:0] pw_clr = clear_all_reg ? 32'hffff_ffff : (w_pwf ? bus.wdata : 32'h0);

  assign p3_flag_next = ((p3_flag_reg & ~p3_clr) | pin_evt) & `LPW_PORT3_MASK;
  assign pw_flag_next = ((pw_flag_reg & ~pw_clr) | pw_evt) & `LPW_PERIPH_FLAG_MASK;

  // Power state sequence
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      lpw_pkg::LPW_ACTIVE: if (sleep_req) state_next = lpw_pkg::LPW_LOW_POWER;
      lpw_pkg::LPW_LOW_POWER: if (any_wake) state_next = lpw_pkg::LPW_WAKING;
      lpw_pkg::LPW_WAKING: state_next = lpw_pkg::LPW_ACTIVE;
      default: state_next = lpw_pkg::LPW_ACTIVE;
    endcase
  end
  assign low_power_state = (state_reg == lpw_pkg::LPW_LOW_POWER);
  assign wake_req = (state_reg == lpw_pkg::LPW_WAKING);

  wire [2:0] ievt = {wake_req, |pw_evt, |pin_evt};
  wire [2:0] iclr = wr_hit(bus, `LPW_OFS_IRQ_CLEAR) ? bus.wdata[2:0] : 3'h0;
  assign ist_next = (ist_reg & ~iclr) | ievt;
  assign irq = |(ist_reg & ien_reg);

  always_comb
  begin
    unique case (bus.addr)
      `LPW_OFS_LOW_POWER_CTRL: rdata_next = {clear_all_reg, 31'h0};
      `LPW_OFS_PORT3_WAKE_FLAGS: rdata_next = p3_flag_reg;
      `LPW_OFS_PORT3_WAKE_ENABLE: rdata_next = p3_en_reg;
      `LPW_OFS_PERIPHERAL_WAKE_FLAGS: rdata_next = pw_flag_reg;
      `LPW_OFS_PERIPHERAL_WAKE_ENABLE: rdata_next = pw_en_reg;
      `LPW_OFS_RETAINED_SCRATCH_0: rdata_next = scratch0_reg;
      `LPW_OFS_RETAINED_SCRATCH_1: rdata_next = scratch1_reg;
      `LPW_OFS_IRQ_STATUS: rdata_next = {29'h0, ist_reg};
      `LPW_OFS_IRQ_ENABLE: rdata_next = {29'h0, ien_reg};
      `LPW_OFS_POWER_MGMT: rdata_next = {31'h0, gpw_en_reg};
      default: rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      state_reg <= lpw_pkg::LPW_ACTIVE;
      p3_en_reg <= `LPW_RESET_VALUE;
      pw_en_reg <= `LPW_RESET_VALUE;
      p3_flag_reg <= `LPW_RESET_VALUE;
      pw_flag_reg <= `LPW_RESET_VALUE;
      scratch0_reg <= `LPW_RESET_VALUE;
      scratch1_reg <= `LPW_RESET_VALUE;
      clear_all_reg <= 1'b0;
      gpw_en_reg <= 1'b0;
      ist_reg <= 3'h0;
      ien_reg <= 3'h0;
      reg_rdata <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      p3_flag_reg <= p3_flag_next;
      pw_flag_reg <= pw_flag_next;
      ist_reg <= ist_next;
      clear_all_reg <= w_ctrl && bus.wdata[`LPW_BIT_FLAG_CLEAR_ALL];
      reg_rdata <= bus.rd ? rdata_next : 32'h0;
      if (wr_hit(bus, `LPW_OFS_PORT3_WAKE_ENABLE))
        p3_en_reg <= bus.wdata & `LPW_PORT3_MASK;
      if (wr_hit(bus, `LPW_OFS_PERIPHERAL_WAKE_ENABLE))
        pw_en_reg <= bus.wdata & `LPW_PERIPH_EN_MASK;
      if (wr_hit(bus, `LPW_OFS_RETAINED_SCRATCH_0))
        scratch0_reg <= bus.wdata;
      if (wr_hit(bus, `LPW_OFS_RETAINED_SCRATCH_1))
        scratch1_reg <= bus.wdata;
      if (wr_hit(bus, `LPW_OFS_POWER_MGMT))
        gpw_en_reg <= bus.wdata[`LPW_BIT_GLOBAL_PIN_WAKE];
      if (wr_hit(bus, `LPW_OFS_IRQ_ENABLE))
        ien_reg <= bus.wdata[2:0];
    end
  end

  pin_wake_leaves_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && pin_wake |=> wake_req ##1 !low_power_state)
    else $error("enabled pin edge did not wake");
  global_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    !gpw_en_reg |-> !pin_wake)
    else $error("pin wake without global enable");
  pin_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    pin_edge[0] |=> p3_flag_reg[0])
    else $error("pin edge lost its flag");
  reset_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    ext_reset_wake |=> pw_flag_reg[17])
    else $error("reset wake flag not set");
  backup_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    backup_wake |=> pw_flag_reg[16])
    else $error("backup wake flag not set");
  comp_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    comparator_zero_wake |=> pw_flag_reg[4])
    else $error("comparator wake flag not set");
  periph_block_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && (pw_en_reg == 32'h0) && !pin_wake && !comparator_zero_wake
      && !ext_reset_wake && !backup_wake |=> !wake_req)
    else $error("disabled source woke device");
  sequence clear_pulse_s;
    w_ctrl && bus.wdata[31] ##1 clear_all_reg;
  endsequence
  clear_all_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    clear_pulse_s |=> !clear_all_reg && (p3_flag_reg[1:0] == $past(pin_evt[1:0])))
    else $error("clear all did not clear or self-clear");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    pw_flag_reg[16] && !clear_all_reg && !(w_pwf && bus.wdata[16]) |=> pw_flag_reg[16])
    else $error("flag dropped without clear");
  scratch_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    !wr_hit(bus, 8'h48) |=> $stable(scratch0_reg))
    else $error("scratch changed without write");
  wake_one_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  sleep_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (state_reg == lpw_pkg::LPW_ACTIVE) && sleep_req |=> low_power_state)
    else $error("sleep request not taken");
  stay_low_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && !any_wake |=> low_power_state)
    else $error("left low power without a wake source");
  any_wake_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && any_wake |=> wake_req)
    else $error("wake source ignored in low power");
  // Wake sequence ends back in active
  sequence wake_s;
    low_power_state && any_wake ##1 wake_req;
  endsequence
  wake_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    wake_s |=> (state_reg == lpw_pkg::LPW_ACTIVE) && !wake_req)
    else $error("wake did not return to active");
  pin_flag1_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    pin_edge[1] |=> p3_flag_reg[1])
    else $error("pin one edge lost its flag");
  pin_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    pins_primed && (pin_s2_reg[0] != pin_last_reg[0]) |-> pin_edge[0])
    else $error("pin level change not seen as edge");
  pin_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    pins_primed && $changed(pin_s1_reg[0]) |=> ##1 p3_flag_reg[0])
    else $error("pin change did not reach flag in time");
  p3_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    w_p3f && bus.wdata[0] && !pin_evt[0] |=> !p3_flag_reg[0])
    else $error("pin flag not cleared by write one");
  p3_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    p3_flag_reg[0] && !clear_all_reg && !(w_p3f && bus.wdata[0]) |=> p3_flag_reg[0])
    else $error("pin flag dropped without clear");
  pw_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    w_pwf && bus.wdata[17] && !ext_reset_wake |=> !pw_flag_reg[17])
    else $error("reset wake flag not cleared by write one");
  clr_self_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    clear_all_reg && !w_ctrl |=> !clear_all_reg)
    else $error("clear all bit stuck");
  clr_all_pw_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    clear_all_reg |=> pw_flag_reg == ($past(pw_evt) & `LPW_PERIPH_FLAG_MASK))
    else $error("clear all left peripheral flags");
  p3_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    p3_flag_reg[31:2] == 30'h0)
    else $error("reserved pin flag bit set");
  pw_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (pw_flag_reg & ~`LPW_PERIPH_FLAG_MASK) == 32'h0)
    else $error("reserved peripheral flag bit set");
  en_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    (pw_en_reg & ~`LPW_PERIPH_EN_MASK) == 32'h0)
    else $error("reserved enable bit set");
  comp_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && comparator_zero_wake && !pw_en_reg[4] && !pin_wake && !periph_wake
      && !ext_reset_wake && !backup_wake |=> !wake_req)
    else $error("disabled comparator woke device");
  periph_any_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_wake |=> wake_req)
    else $error("enabled peripheral did not wake");
  lpcomp_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[26] && pw_en_reg[26] |=> wake_req)
    else $error("comparator interrupt did not wake");
  spi_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[25] && pw_en_reg[25] |=> wake_req)
    else $error("serial port interrupt did not wake");
  i2c_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[21] && pw_en_reg[21] |=> wake_req)
    else $error("bus controller interrupt did not wake");
  uart_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[20] && pw_en_reg[20] |=> wake_req)
    else $error("low power serial port did not wake");
  timer_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[15] && pw_en_reg[15] |=> wake_req)
    else $error("low power timer did not wake");
  core_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[10] && pw_en_reg[10] |=> wake_req)
    else $error("secondary core did not wake");
  wdog_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && periph_irq[9] && pw_en_reg[9] |=> wake_req)
    else $error("watchdog one did not wake");
  backup_wakes_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    low_power_state && backup_wake |=> wake_req)
    else $error("backup wake ignored");
  scratch1_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    !wr_hit(bus, `LPW_OFS_RETAINED_SCRATCH_1) |=> $stable(scratch1_reg))
    else $error("scratch one changed without write");
  scratch_write_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    wr_hit(bus, `LPW_OFS_RETAINED_SCRATCH_0) |=> scratch0_reg == $past(bus.wdata))
    else $error("scratch write lost");
  scratch_read_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
    bus.rd && (bus.addr == 8'h48) |=> reg_rdata == $past(scratch0_reg))
    else $error("scratch read wrong");
endmodule : lpw_wake_sources
`default_nettype wire

// ### tb/lpw_far_side.sv
// Far-side model: wake pins, peripheral interrupts and wake events
`timescale 1ns/1ps
`default_nettype none
module lpw_far_side (
  input wire logic ref_clk, // System clock
  output logic [1:0] port3_pin, // Wake pins
  output logic [31:0] periph_irq, // Peripheral interrupts
  output logic [2:0] evt // Ext reset, backup, comparator zero
);
  initial
  begin
    port3_pin = 2'h0;
    periph_irq = 32'h0;
    evt = 3'h0;
  end
  // Pins hold their level until told to change
  task automatic toggle_pin(input int i);
    @(posedge ref_clk);
    port3_pin[i] <= ~port3_pin[i];
  endtask : toggle_pin
  // One-cycle pulse, then lines drop back
  task automatic pulse(input logic [31:0] irq, input logic [2:0] e);
    @(posedge ref_clk);
    periph_irq <= irq;
    evt <= e;
    @(posedge ref_clk);
    periph_irq <= 32'h0;
    evt <= 3'h0;
  endtask : pulse
endmodule : lpw_far_side
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench of the wake-up source block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, rstn, reg_wr, reg_rd, sleep_req, low_power_state, wake_req, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, periph_irq, d;
  logic [1:0] port3_pin;
  logic [2:0] evt;
  int n_fail, tests_run;
  lpw_far_side far (.ref_clk(ref_clk), .port3_pin(port3_pin), .periph_irq(periph_irq),
    .evt(evt));
  lpw_wake_sources dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port3_pin(port3_pin), .periph_irq(periph_irq), .ext_reset_wake(evt[2]),
    .backup_wake(evt[1]), .comparator_zero_wake(evt[0]), .sleep_req(sleep_req),
    .low_power_state(low_power_state), .wake_req(wake_req), .irq(irq));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk($sformatf("reg_%h", a), e, d);
  endtask : rchk
  task automatic sleep;
    @(posedge ref_clk);
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("low_power_state", 32'h1, {31'h0, low_power_state});
  endtask : sleep
  // Wake pulse must show within the window, and state must follow
  task automatic expect_wake(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (12)
    begin
      #1 if (wake_req === 1'b1) seen = 1'b1;
      @(posedge ref_clk);
    end
    #1;
    chk("wake_req", {31'h0, e}, {31'h0, seen});
    chk("low_power_state", {31'h0, ~e}, {31'h0, low_power_state});
  endtask : expect_wake
  task automatic chk_irq(input logic e);
    @(posedge ref_clk);
    #1 chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : chk_irq
  task automatic t_reset;
    logic [7:0] a [6] = '{8'h20, 8'h30, 8'h34, 8'h48, 8'h4c, 8'h40};
    foreach (a[i]) rchk(a[i], 32'h0);
  endtask : t_reset
  task automatic t_scratch;
    wr(8'h48, 32'ha5a5_0f0f);
    wr(8'h4c, 32'h1234_5678);
    sleep;
    rchk(8'h48, 32'ha5a5_0f0f);
    rchk(8'h4c, 32'h1234_5678);
    far.pulse(32'h0, 3'h4);
    expect_wake(1'b1);
  endtask : t_scratch
  task automatic t_periph;
    for (int i = 8; i <= 26; i++)
    begin
      wr(8'h34, 32'h0);
      sleep;
      far.pulse(32'h1 << i, 3'h0);
      expect_wake(1'b0);
      wr(8'h34, 32'h1 << i);
      rchk(8'h34, 32'h1 << i);
      far.pulse(32'h1 << i, 3'h0);
      expect_wake(1'b1);
    end
    wr(8'h34, 32'h0);
  endtask : t_periph
  task automatic t_pins;
    wr(8'h00, 32'h8000_0000);
    wr(8'h20, 32'h3);
    wr(8'h6c, 32'h1);
    sleep;
    far.toggle_pin(0);
    expect_wake(1'b1);
    rchk(8'h1c, 32'h1);
    wr(8'h1c, 32'h1);
    wr(8'h6c, 32'h0);
    sleep;
    far.toggle_pin(1);
    expect_wake(1'b0);
    rchk(8'h1c, 32'h2);
    wr(8'h1c, 32'h2);
    wr(8'h6c, 32'h1);
    far.toggle_pin(1);
    expect_wake(1'b1);
    rchk(8'h1c, 32'h2);
  endtask : t_pins
  task automatic t_flags;
    wr(8'h00, 32'h8000_0000);
    far.pulse(32'h0, 3'h7);
    rchk(8'h30, 32'h0003_0010);
    wr(8'h30, 32'h0);
    rchk(8'h30, 32'h0003_0010);
    wr(8'h30, 32'h0001_0000);
    rchk(8'h30, 32'h0002_0010);
    fork
      wr(8'h30, 32'h0000_0010);
      far.pulse(32'h0, 3'h1);
    join
    rchk(8'h30, 32'h0002_0010);
    far.toggle_pin(0);
    repeat (6) @(posedge ref_clk);
    wr(8'h00, 32'h8000_0000);
    rchk(8'h30, 32'h0);
    rchk(8'h1c, 32'h0);
    rchk(8'h00, 32'h0);
  endtask : t_flags
  task automatic t_irq;
    wr(8'h64, 32'h0);
    wr(8'h68, 32'h7);
    far.pulse(32'h0, 3'h2);
    rchk(8'h60, 32'h2);
    chk_irq(1'b0);
    wr(8'h64, 32'h2);
    chk_irq(1'b1);
    wr(8'h68, 32'h2);
    chk_irq(1'b0);
    rchk(8'h60, 32'h0);
  endtask : t_irq
  task automatic test_done;
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial
  begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_req = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_scratch;
    t_periph;
    t_pins;
    t_flags;
    t_irq;
    test_done;
  end
  // About 900 cycles expected; allow over twenty times that
  initial
  begin
    #160000;
    n_fail++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
